// [hw/fcd_pkg.sv]
// Purpose: Constants for the flash command dispatcher.
// Assumes: APB slave, 32-bit data, one word per register.
// Notes: Offsets are of our own choosing.
//
// Functional notes
// - Codes 01, 02, 03 decode as verify all, verify block, verify section.
// - Code 04 reads back the 64-byte one-time field.
// - Code 06 programs up to two longwords in one block.
// - Code 07 programs the one-time field, once only.
// - Code 08 erases all blocks only if both protect disables are set.
// - Code 09 erases one block only if both protect disables are set.
// - Code 0A erases the addressed sector.
// - Code 0B erases all, verifies, then releases security.
// - Code 0C compares keys and releases security on a match.
// - Codes 0D and 0E set user and factory read margin.
// - Program or erase before divider init sets access error, no run.
// - Undefined command code sets access error, no run.
// - Array reads while busy return invalid data.
// - Verify all checks whole array; failure sets both result bits.
// - Verify all needs index 000, else access error.
// - Verify block takes 24-bit address from index 000 and 001.
// - Verify block needs index 001, else access error.
// - Bad verify address sets access error; verify never sets violation.
// - Read error during verify also sets both result bits.
// - Divider, unprotect, mass erase or unsecure, then device unsecures.
// - Failed key compare blocks key verify until reset.
package fcd_pkg;
	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_INDEX = 8'h04;
	localparam logic [7:0] OFF_PARAM = 8'h08;
	localparam logic [7:0] OFF_DIVIDER = 8'h0C;
	localparam logic [7:0] OFF_PROTECT = 8'h10;
	localparam logic [7:0] OFF_SECURITY = 8'h14;
	// ****************************************************************
	// Status, divider and protect bit positions
	// ****************************************************************
	localparam int ST_CCF = 7;
	localparam int ST_ACC = 5;
	localparam int ST_PV = 4;
	localparam int ST_RS1 = 1;
	localparam int ST_RS0 = 0;
	localparam int DIV_DONE = 7;
	localparam int PR_HDIS = 1;
	localparam int PR_OEN = 0;
	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [7:0] CMD_VFY_ALL = 8'h01;
	localparam logic [7:0] CMD_VFY_BLK = 8'h02;
	localparam logic [7:0] CMD_VFY_SEC = 8'h03;
	localparam logic [7:0] CMD_RD_ONCE = 8'h04;
	localparam logic [7:0] CMD_PGM = 8'h06;
	localparam logic [7:0] CMD_PGM_ONCE = 8'h07;
	localparam logic [7:0] CMD_ERS_ALL = 8'h08;
	localparam logic [7:0] CMD_ERS_BLK = 8'h09;
	localparam logic [7:0] CMD_ERS_SEC = 8'h0A;
	localparam logic [7:0] CMD_UNSEC = 8'h0B;
	localparam logic [7:0] CMD_KEY = 8'h0C;
	localparam logic [7:0] CMD_MRG_USR = 8'h0D;
	localparam logic [7:0] CMD_MRG_FAC = 8'h0E;
	// ****************************************************************
	// Index values and limits
	// ****************************************************************
	localparam logic [2:0] IX_0 = 3'h0;
	localparam logic [2:0] IX_1 = 3'h1;
	localparam logic [2:0] IX_2 = 3'h2;
	localparam logic [2:0] IX_3 = 3'h3;
	localparam logic [2:0] IX_5 = 3'h5;
	localparam int NPARAM = 6;
	localparam logic [23:0] FLASH_LO = 24'h00C000;
	localparam logic [23:0] FLASH_HI = 24'h00FFFF;
	localparam logic [1:0] SEC_UNSEC = 2'h2;
	localparam logic [1:0] SEC_SECURE = 2'h0;
	localparam logic [7:0] PROT_RESET = 8'h00;
	// Sequencer states; code 10 is never entered
	typedef enum logic [1:0] {
		FCD_IDLE = 2'b00,
		FCD_RUN = 2'b01,
		FCD_DONE = 2'b11
	} fcd_state_t;
endpackage

// [hw/fcd_dispatch.sv]
// Purpose: Flash command dispatcher with APB registers.
// Assumes: Array engine answers each start with one done pulse.
// Notes: Registers answer with zero wait states.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module fcd_dispatch (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic arr_start,
	output logic [7:0] arr_cmd,
	output logic [23:0] arr_addr,
	output logic arr_busy,
	output logic array_read_invalid,
	output logic unsecured,
	input wire logic arr_done,
	input wire logic arr_fail,
	input wire logic arr_key_ok,
	input wire logic [15:0] arr_rdata
);
	// ****************************************************************
	// Registers
	// ****************************************************************
	logic ccf_reg, acc_reg, pv_reg, rs1_reg, rs0_reg;
	logic [2:0] index_reg;
	logic [15:0] param_reg [0:5];
	logic [7:0] div_reg;
	logic div_done_reg;
	logic [1:0] prot_reg;
	logic [1:0] sec_reg;
	logic key_lock_reg;
	logic once_done_reg;
	logic [2:0] index_r;
	fcd_pkg::fcd_state_t state_reg;
	logic wr, rd, launch;
	logic [7:0] cmd;
	logic [23:0] addr;
	logic cmd_ok, idx_ok, addr_ok, prot_ok, bad;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign cmd = param_reg[0][15:8];
	assign addr = {param_reg[0][7:0], param_reg[1]};
	// Launch: software writes one to the complete flag while it is set
	assign launch = wr && (paddr == fcd_pkg::OFF_STATUS) &&
		pwdata[fcd_pkg::ST_CCF] && ccf_reg;

	// ****************************************************************
	// Launch checks
	// ****************************************************************
	// Decode; unlisted codes are errors
	always_comb begin
		cmd_ok = 1'b1;
		idx_ok = 1'b1;
		unique case (cmd)
			fcd_pkg::CMD_VFY_ALL: idx_ok = (index_reg == fcd_pkg::IX_0);
			fcd_pkg::CMD_VFY_BLK: idx_ok = (index_reg == fcd_pkg::IX_1);
			fcd_pkg::CMD_VFY_SEC: idx_ok = (index_reg == fcd_pkg::IX_2);
			fcd_pkg::CMD_RD_ONCE: idx_ok = (index_reg == fcd_pkg::IX_1);
			fcd_pkg::CMD_PGM: idx_ok = (index_reg == fcd_pkg::IX_3) ||
				(index_reg == fcd_pkg::IX_5);
			fcd_pkg::CMD_PGM_ONCE: idx_ok = !once_done_reg;
			fcd_pkg::CMD_ERS_ALL, fcd_pkg::CMD_ERS_BLK,
			fcd_pkg::CMD_ERS_SEC, fcd_pkg::CMD_UNSEC,
			fcd_pkg::CMD_MRG_USR, fcd_pkg::CMD_MRG_FAC: idx_ok = 1'b1;
			fcd_pkg::CMD_KEY: idx_ok = !key_lock_reg;
			default: cmd_ok = 1'b0;
		endcase
	end

	// Address must land inside the array for verify block, verify section, program and sector erase
	assign addr_ok = !(cmd == fcd_pkg::CMD_VFY_BLK ||
		cmd == fcd_pkg::CMD_VFY_SEC || cmd == fcd_pkg::CMD_PGM ||
		cmd == fcd_pkg::CMD_ERS_SEC) ||
		(addr >= fcd_pkg::FLASH_LO && addr <= fcd_pkg::FLASH_HI);
	// Erase all, block erase and unsecure need both disable bits; shown as a violation
	assign prot_ok = !(cmd == fcd_pkg::CMD_ERS_ALL ||
		cmd == fcd_pkg::CMD_ERS_BLK || cmd == fcd_pkg::CMD_UNSEC) ||
		(prot_reg[fcd_pkg::PR_HDIS] && prot_reg[fcd_pkg::PR_OEN]);
	// Program or erase before the divider is written is refused
	assign bad = !cmd_ok || !idx_ok || !addr_ok ||
		(!div_done_reg && cmd >= fcd_pkg::CMD_PGM &&
		cmd <= fcd_pkg::CMD_UNSEC);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Run state and complete flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= fcd_pkg::FCD_IDLE;
			ccf_reg <= 1'b1;
			arr_start <= 1'b0;
			arr_cmd <= 8'h00;
			arr_addr <= 24'h000000;
		end else begin
			arr_start <= 1'b0;
			unique case (state_reg)
				fcd_pkg::FCD_IDLE: begin
					if (launch && !bad && prot_ok && !acc_reg && !pv_reg) begin
						state_reg <= fcd_pkg::FCD_RUN;
						ccf_reg <= 1'b0;
						arr_start <= 1'b1;
						arr_cmd <= cmd;
						arr_addr <= addr;
					end
				end
				fcd_pkg::FCD_RUN: begin
					if (arr_done) begin
						state_reg <= fcd_pkg::FCD_DONE;
					end
				end
				fcd_pkg::FCD_DONE: begin
					state_reg <= fcd_pkg::FCD_IDLE;
					ccf_reg <= 1'b1;
				end
				default: state_reg <= fcd_pkg::FCD_IDLE;
			endcase
		end
	end

	// Busy and invalid-read marker track the complete flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arr_busy <= 1'b0;
			array_read_invalid <= 1'b0;
		end else begin
			arr_busy <= (state_reg != fcd_pkg::FCD_IDLE);
			array_read_invalid <= !ccf_reg;
		end
	end

	// ****************************************************************
	// Status flags
	// ****************************************************************
	// Errors set over write-one clear, so an event is never lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_reg <= 1'b0;
			pv_reg <= 1'b0;
			rs1_reg <= 1'b0;
			rs0_reg <= 1'b0;
		end else begin
			if (launch && bad)
				acc_reg <= 1'b1;
			else if (wr && paddr == fcd_pkg::OFF_STATUS && pwdata[fcd_pkg::ST_ACC])
				acc_reg <= 1'b0;
			if (launch && !bad && !prot_ok)
				pv_reg <= 1'b1;
			else if (wr && paddr == fcd_pkg::OFF_STATUS && pwdata[fcd_pkg::ST_PV])
				pv_reg <= 1'b0;
			// Only a launch that really starts clears old results
			if (launch && !bad && prot_ok && !acc_reg && !pv_reg) begin
				rs1_reg <= 1'b0;
				rs0_reg <= 1'b0;
			end else if (state_reg == fcd_pkg::FCD_RUN && arr_done) begin
				rs1_reg <= arr_fail;
				rs0_reg <= arr_fail;
			end
		end
	end

	// ****************************************************************
	// Security, key lock and one-time field
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_reg <= fcd_pkg::SEC_SECURE;
			key_lock_reg <= 1'b0;
			once_done_reg <= 1'b0;
		end else if (state_reg == fcd_pkg::FCD_RUN && arr_done) begin
			if ((arr_cmd == fcd_pkg::CMD_UNSEC || arr_cmd == fcd_pkg::CMD_ERS_ALL)
				&& !arr_fail)
				sec_reg <= fcd_pkg::SEC_UNSEC;
			if (arr_cmd == fcd_pkg::CMD_KEY) begin
				if (arr_key_ok && !arr_fail)
					sec_reg <= fcd_pkg::SEC_UNSEC;
				else
					key_lock_reg <= 1'b1;
			end
			if (arr_cmd == fcd_pkg::CMD_PGM_ONCE && !arr_fail)
				once_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			unsecured <= 1'b0;
		else
			unsecured <= (sec_reg == fcd_pkg::SEC_UNSEC);
	end

	// ****************************************************************
	// Parameter, index, divider and protection registers
	// ****************************************************************
	// Read-once data returns into the indexed slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < fcd_pkg::NPARAM; i++)
				param_reg[i] <= 16'h0000;
		end else if (state_reg == fcd_pkg::FCD_RUN && arr_done &&
			arr_cmd == fcd_pkg::CMD_RD_ONCE) begin
			param_reg[index_reg] <= arr_rdata;
		end else if (wr && paddr == fcd_pkg::OFF_PARAM && ccf_reg &&
			index_reg < 3'(fcd_pkg::NPARAM)) begin
			param_reg[index_reg] <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_reg <= 3'h0;
			div_reg <= 8'h00;
			div_done_reg <= 1'b0;
			prot_reg <= fcd_pkg::PROT_RESET[1:0];
		end else if (wr && ccf_reg) begin
			if (paddr == fcd_pkg::OFF_INDEX)
				index_reg <= pwdata[2:0];
			if (paddr == fcd_pkg::OFF_DIVIDER && !div_done_reg) begin
				div_reg <= pwdata[7:0];
				div_done_reg <= 1'b1;
			end
			if (paddr == fcd_pkg::OFF_PROTECT)
				prot_reg <= pwdata[1:0];
		end
	end

	// ****************************************************************
	// APB read path
	// ****************************************************************
	assign index_r = index_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					fcd_pkg::OFF_STATUS: prdata <= {24'h000000, ccf_reg, 1'b0,
						acc_reg, pv_reg, 2'b00, rs1_reg, rs0_reg};
					fcd_pkg::OFF_INDEX: prdata <= {29'h00000000, index_r};
					fcd_pkg::OFF_PARAM: prdata <= (index_r < 3'(fcd_pkg::NPARAM)) ?
						{16'h0000, param_reg[index_r]} : 32'h00000000;
					fcd_pkg::OFF_DIVIDER: prdata <= {24'h000000, div_done_reg,
						div_reg[6:0]};
					fcd_pkg::OFF_PROTECT: prdata <= {30'h00000000, prot_reg};
					fcd_pkg::OFF_SECURITY: prdata <= {29'h00000000, key_lock_reg,
						sec_reg};
					default: pslverr <= 1'b1;
				endcase
			end else if (psel && !penable) begin
				pslverr <= !(paddr == fcd_pkg::OFF_STATUS ||
					paddr == fcd_pkg::OFF_INDEX || paddr == fcd_pkg::OFF_PARAM ||
					paddr == fcd_pkg::OFF_DIVIDER || paddr == fcd_pkg::OFF_PROTECT ||
					paddr == fcd_pkg::OFF_SECURITY);
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_undef_err;
		@(posedge pclk) disable iff (!presetn)
		launch && !cmd_ok |=> acc_reg && !arr_start;
	endproperty
	a_undef_err: assert property (p_undef_err)
		else $error("undefined code ran");

	property p_div_err;
		@(posedge pclk) disable iff (!presetn)
		launch && !div_done_reg && cmd == fcd_pkg::CMD_ERS_SEC |=> acc_reg;
	endproperty
	a_div_err: assert property (p_div_err)
		else $error("no divider error");

	property p_vall_idx;
		@(posedge pclk) disable iff (!presetn)
		launch && cmd == fcd_pkg::CMD_VFY_ALL && index_reg != fcd_pkg::IX_0
		|=> acc_reg;
	endproperty
	a_vall_idx: assert property (p_vall_idx)
		else $error("verify all index");

	property p_vblk_idx;
		@(posedge pclk) disable iff (!presetn)
		launch && cmd == fcd_pkg::CMD_VFY_BLK && index_reg != fcd_pkg::IX_1
		|=> acc_reg;
	endproperty
	a_vblk_idx: assert property (p_vblk_idx)
		else $error("verify block index");

	property p_fail_rs;
		@(posedge pclk) disable iff (!presetn)
		state_reg == fcd_pkg::FCD_RUN && arr_done && arr_fail
		|=> rs1_reg && rs0_reg ##1 ccf_reg;
	endproperty
	a_fail_rs: assert property (p_fail_rs)
		else $error("result bits");

	property p_invalid;
		@(posedge pclk) disable iff (!presetn)
		arr_start |=> array_read_invalid;
	endproperty
	a_invalid: assert property (p_invalid)
		else $error("read not blocked");

	property p_prot;
		@(posedge pclk) disable iff (!presetn)
		launch && !bad && cmd == fcd_pkg::CMD_ERS_ALL &&
		!prot_reg[fcd_pkg::PR_OEN]
		|=> pv_reg && !arr_busy;
	endproperty
	a_prot: assert property (p_prot)
		else $error("erase while protected");

	property p_key_lock;
		@(posedge pclk) disable iff (!presetn)
		key_lock_reg |=> key_lock_reg &&
		!(arr_start && arr_cmd == fcd_pkg::CMD_KEY);
	endproperty
	a_key_lock: assert property (p_key_lock)
		else $error("key relaunch");

	property p_busy_param;
		@(posedge pclk) disable iff (!presetn)
		!ccf_reg && !arr_done |=> $stable(param_reg[0]);
	endproperty
	a_busy_param: assert property (p_busy_param)
		else $error("param changed");

	// Out-of-range block address never reaches the array
	property p_vblk_addr;
		@(posedge pclk) disable iff (!presetn)
		launch && cmd == fcd_pkg::CMD_VFY_BLK &&
		(addr < fcd_pkg::FLASH_LO || addr > fcd_pkg::FLASH_HI)
		|=> acc_reg && !arr_start;
	endproperty
	a_vblk_addr: assert property (p_vblk_addr)
		else $error("verify address accepted");

	// Block erase with protection still on is a violation
	property p_prot_blk;
		@(posedge pclk) disable iff (!presetn)
		launch && !bad && cmd == fcd_pkg::CMD_ERS_BLK &&
		!(prot_reg[fcd_pkg::PR_HDIS] && prot_reg[fcd_pkg::PR_OEN])
		|=> pv_reg && !arr_start;
	endproperty
	a_prot_blk: assert property (p_prot_blk)
		else $error("block erase while protected");

	// One-time field is never programmed twice
	property p_once;
		@(posedge pclk) disable iff (!presetn)
		once_done_reg |=> once_done_reg &&
		!(arr_start && arr_cmd == fcd_pkg::CMD_PGM_ONCE);
	endproperty
	a_once: assert property (p_once)
		else $error("one-time field relaunched");

	// Read-once data lands in the indexed slot
	property p_rd_once;
		@(posedge pclk) disable iff (!presetn)
		state_reg == fcd_pkg::FCD_RUN && arr_done &&
		arr_cmd == fcd_pkg::CMD_RD_ONCE
		|=> param_reg[index_reg] == $past(arr_rdata);
	endproperty
	a_rd_once: assert property (p_rd_once)
		else $error("read-once data lost");

	c_launch: cover property (@(posedge pclk) disable iff (!presetn) arr_start);
	c_fail: cover property (@(posedge pclk) disable iff (!presetn)
		arr_done && arr_fail);
	c_unsec: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(unsecured));
	c_key_lock: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(key_lock_reg));
endmodule // fcd_dispatch

// [test/fcd_array_model.sv]
// Purpose: Behavioural flash array facing the command dispatcher.
// Assumes: One done pulse per start, after a delay set by the bench.
// Notes: Qualified outputs scramble outside the done pulse.
`timescale 1ns/10ps
module fcd_array_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic arr_start,
	input wire logic [7:0] delay,
	input wire logic fail_cfg,
	input wire logic key_cfg,
	output logic arr_done,
	output logic arr_fail,
	output logic arr_key_ok,
	output logic [15:0] arr_rdata
);
	logic [7:0] cnt_reg;
	logic [15:0] noise_reg;
	// ****************************************************************
	// Algorithm timing
	// ****************************************************************
	// Countdown from start to the single done pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 8'h00;
			arr_done <= 1'b0;
		end else begin
			if (arr_start) begin
				cnt_reg <= delay;
			end else if (cnt_reg != 8'h00) begin
				cnt_reg <= cnt_reg - 8'h01;
			end
			arr_done <= (cnt_reg == 8'h01);
		end
	end
	// Changing pattern so stale results never look valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			noise_reg <= 16'h0000;
		end else begin
			noise_reg <= {noise_reg[14:0], ~noise_reg[15]};
		end
	end
	// Results only meaningful alongside done
	assign arr_fail = arr_done ? fail_cfg : noise_reg[0];
	assign arr_key_ok = arr_done ? key_cfg : noise_reg[1];
	assign arr_rdata = arr_done ? 16'hA5C3 : noise_reg;
endmodule // fcd_array_model

// [test/flash_command_dispatcher_tb_top.sv]
// Purpose: Self-checking bench for the flash command dispatcher.
// Assumes: Zero-wait APB slave; array model answers after a delay.
// Notes: Refused launches are judged by the array start count.
`timescale 1ns/10ps
module flash_command_dispatcher_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, arr_start, arr_busy, array_read_invalid, unsecured;
	logic [7:0] arr_cmd, last_cmd;
	logic [23:0] arr_addr, last_addr;
	logic arr_done, arr_fail, arr_key_ok, er;
	logic [15:0] arr_rdata;
	logic [7:0] delay = 8'h14;
	logic fail_cfg = 1'b0;
	logic key_cfg = 1'b0;
	logic [7:0] runs [4] = '{8'h06, 8'h0A, 8'h0D, 8'h0E};
	logic [2:0] run_ix [4] = '{3'h3, 3'h0, 3'h0, 3'h0};
	logic [31:0] rd;
	logic [7:0] codes [4] = '{8'h00, 8'h05, 8'h0F, 8'hFF};
	int n_start = 0;
	int n_fail = 0;
	int comparisons = 0;
	int s;
	always #5 pclk = ~pclk;
	fcd_dispatch dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.arr_start(arr_start), .arr_cmd(arr_cmd), .arr_addr(arr_addr),
		.arr_busy(arr_busy), .array_read_invalid(array_read_invalid),
		.unsecured(unsecured), .arr_done(arr_done), .arr_fail(arr_fail),
		.arr_key_ok(arr_key_ok), .arr_rdata(arr_rdata));
	fcd_array_model far (.pclk(pclk), .presetn(presetn),
		.arr_start(arr_start), .delay(delay), .fail_cfg(fail_cfg),
		.key_cfg(key_cfg), .arr_done(arr_done), .arr_fail(arr_fail),
		.arr_key_ok(arr_key_ok), .arr_rdata(arr_rdata));
	// Record every launch that reaches the array
	always @(posedge pclk) begin
		if (arr_start === 1'b1) begin
			n_start <= n_start + 1;
			last_cmd <= arr_cmd;
			last_addr <= arr_addr;
		end
	end
	// ****************************************************************
	// Bus and check tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// Request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) n_fail++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic stat(input logic [7:0] exp);
		apb(1'b0, fcd_pkg::OFF_STATUS, 32'h0);
		chk("status", {24'h0, exp}, rd);
	endtask
	// Parameters at index 0 and 1, then final index and launch
	task automatic launch(input logic [7:0] cmd, input logic [23:0] ad,
		input logic [2:0] ix);
		wr(fcd_pkg::OFF_INDEX, 32'h0);
		wr(fcd_pkg::OFF_PARAM, {16'h0, cmd, ad[23:16]});
		wr(fcd_pkg::OFF_INDEX, 32'h1);
		wr(fcd_pkg::OFF_PARAM, {16'h0, ad[15:0]});
		wr(fcd_pkg::OFF_INDEX, {29'h0, ix});
		wr(fcd_pkg::OFF_STATUS, 32'h80);
	endtask
	// Polls instead of assuming the algorithm length
	task automatic wait_done();
		int k;
		k = 0;
		do begin
			apb(1'b0, fcd_pkg::OFF_STATUS, 32'h0);
			k++;
		end while (rd[7] !== 1'b1 && k < 100);
		if (rd[7] !== 1'b1) n_fail++;
	endtask
	// Refused launch: error flags as given, array never started
	task automatic refused(input logic [7:0] cmd, input logic [23:0] ad,
		input logic [2:0] ix, input logic [7:0] exp);
		s = n_start;
		launch(cmd, ad, ix);
		stat(exp);
		chk("starts", s, n_start);
		wr(fcd_pkg::OFF_STATUS, 32'h30);
	endtask
	// Mid-run reset with the bus idle, held like power-on
	task automatic rst();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic results();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Hang guard, far beyond the expected run length
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		results();
	end
	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		stat(8'h80);
		chk("unsecured", 32'h0, {31'h0, unsecured});
		apb(1'b0, 8'h40, 32'h0);
		chk("pslverr", 32'h1, {31'h0, er});
		refused(fcd_pkg::CMD_PGM, 24'h00C000, fcd_pkg::IX_3, 8'hA0);
		refused(fcd_pkg::CMD_ERS_SEC, 24'h00C000, 3'h0, 8'hA0);
		stat(8'h80);
		wr(fcd_pkg::OFF_DIVIDER, 32'h13);
		foreach (codes[i]) refused(codes[i], 24'h00C000, 3'h0, 8'hA0);
		refused(fcd_pkg::CMD_VFY_ALL, 24'h00C000, 3'h1, 8'hA0);
		refused(fcd_pkg::CMD_VFY_BLK, 24'h00C010, 3'h0, 8'hA0);
		refused(fcd_pkg::CMD_VFY_BLK, 24'h001000, 3'h1, 8'hA0);
		refused(fcd_pkg::CMD_ERS_ALL, 24'h00C000, 3'h0, 8'h90);
		refused(fcd_pkg::CMD_ERS_BLK, 24'h00C000, 3'h0, 8'h90);
		// Verify family, each with its own final index
		for (int c = 1; c <= 3; c++) begin
			launch(c[7:0], 24'h00C010, c[2:0] - 3'h1);
			repeat (3) @(posedge pclk);
			chk("read invalid", 32'h1, {31'h0, array_read_invalid});
			chk("busy", 32'h1, {31'h0, arr_busy});
			wait_done();
			chk("invalid", 32'h0, {31'h0, array_read_invalid});
			chk("busy", 32'h0, {31'h0, arr_busy});
			chk("command", c, {24'h0, last_cmd});
			chk("status", 32'h80, rd);
			if (c == 2) chk("address", 32'h00C010, {8'h0, last_addr});
		end
		// Writes and relaunch while busy are ignored
		delay <= 8'h28;
		s = n_start;
		launch(fcd_pkg::CMD_VFY_ALL, 24'h00C010, fcd_pkg::IX_0);
		wr(fcd_pkg::OFF_INDEX, 32'h1);
		wr(fcd_pkg::OFF_PARAM, 32'h0E00);
		wr(fcd_pkg::OFF_STATUS, 32'h80);
		wait_done();
		chk("starts", s + 1, n_start);
		apb(1'b0, fcd_pkg::OFF_PARAM, 32'h0);
		chk("param", 32'h0100, {16'h0, rd[15:0]});
		// Failed blank check sets both result bits
		delay <= 8'h14;
		fail_cfg <= 1'b1;
		launch(fcd_pkg::CMD_VFY_BLK, 24'h00C010, fcd_pkg::IX_1);
		wait_done();
		chk("status", 32'h83, rd);
		fail_cfg <= 1'b0;
		launch(fcd_pkg::CMD_VFY_ALL, 24'h00C000, fcd_pkg::IX_0);
		wait_done();
		chk("status", 32'h80, rd);
		// Program, sector erase and both margin codes run once each
		foreach (runs[i]) begin
			launch(runs[i], 24'h00C100, run_ix[i]);
			wait_done();
			chk("command", {24'h0, runs[i]},
				{24'h0, last_cmd});
		end
		launch(fcd_pkg::CMD_RD_ONCE, 24'h000003, fcd_pkg::IX_1);
		wait_done();
		apb(1'b0, fcd_pkg::OFF_PARAM, 32'h0);
		chk("read once", 32'hA5C3, rd);
		launch(fcd_pkg::CMD_PGM_ONCE, 24'h000000, fcd_pkg::IX_0);
		wait_done();
		refused(fcd_pkg::CMD_PGM_ONCE, 24'h000000, 3'h0, 8'hA0);
		// Wrong key locks the key command until reset
		launch(fcd_pkg::CMD_KEY, 24'h000000, fcd_pkg::IX_0);
		wait_done();
		apb(1'b0, fcd_pkg::OFF_SECURITY, 32'h0);
		chk("security", 32'h4, rd);
		refused(fcd_pkg::CMD_KEY, 24'h000000, 3'h0, 8'hA0);
		chk("unsecured", 32'h0, {31'h0, unsecured});
		// Protection opened, then erase all unsecures
		wr(fcd_pkg::OFF_PROTECT, 32'h3);
		apb(1'b0, fcd_pkg::OFF_PROTECT, 32'h0);
		chk("protect", 32'h3, {30'h0, rd[1:0]});
		launch(fcd_pkg::CMD_ERS_ALL, 24'h00C000, fcd_pkg::IX_0);
		wait_done();
		chk("command", 32'h08, {24'h0, last_cmd});
		chk("unsecured", 32'h1, {31'h0, unsecured});
		// Reset clears the key lock; a matching key unsecures
		rst();
		stat(8'h80);
		apb(1'b0, fcd_pkg::OFF_SECURITY, 32'h0);
		chk("security", 32'h0, rd);
		key_cfg <= 1'b1;
		launch(fcd_pkg::CMD_KEY, 24'h000000, fcd_pkg::IX_0);
		wait_done();
		chk("unsecured", 32'h1, {31'h0, unsecured});
		// Debug path: reset, divider, unprotect, then unsecure
		rst();
		chk("unsecured", 32'h0, {31'h0, unsecured});
		wr(fcd_pkg::OFF_DIVIDER, 32'h13);
		wr(fcd_pkg::OFF_PROTECT, 32'h3);
		launch(fcd_pkg::CMD_UNSEC, 24'h00C000, fcd_pkg::IX_0);
		wait_done();
		chk("status", 32'h80, rd);
		chk("unsecured", 32'h1, {31'h0, unsecured});
		apb(1'b0, fcd_pkg::OFF_SECURITY, 32'h0);
		chk("security", 32'h2, {30'h0, rd[1:0]});
		results();
	end
endmodule // flash_command_dispatcher_tb_top
